/* File: logic/pwm_stage_pkg.sv */
package pwm_stage_pkg;
   // Clock rate of clk_i
   localparam int unsigned CLK_HZ = 40000000;
   // Over-current back-off time
   localparam int unsigned BACKOFF_MS = 85;
   localparam int unsigned BACKOFF_CYCLES = (CLK_HZ / 1000) * BACKOFF_MS;
   // Retry attempts before latching shutdown
   localparam int unsigned RETRY_MAX = 5;
   // Master clock selection codes
   localparam logic [1:0] CLKSEL_18M432 = 2'h0;
   localparam logic [1:0] CLKSEL_24M576 = 2'h1;
   localparam logic [1:0] CLKSEL_27M000 = 2'h2;
   // Master clock cycles per PWM frame
   localparam logic [7:0] FRAME_18M432 = 8'h30;
   localparam logic [7:0] FRAME_24M576 = 8'h40;
   localparam logic [7:0] FRAME_27M000 = 8'h40;
   // Quantization levels per frame
   localparam logic [7:0] LEVELS_48 = 8'h30;
   localparam logic [7:0] LEVELS_64 = 8'h40;
   // Number of modulator pairs
   localparam int unsigned NUM_PAIRS = 3;
   localparam int unsigned HW_PAIRS = 2;
   typedef enum logic [1:0] {ST_RUN, ST_BACKOFF, ST_PROBE, ST_SHUTDOWN} prot_state_e;
endpackage : pwm_stage_pkg

/* File: logic/pwm_modulator.sv */
`timescale 1ns/1ps
`default_nettype none
// One modulator: frame counter from the local clock, duty compare
module pwm_modulator
   import pwm_stage_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic active_i,
   input wire logic [7:0] frame_len_i,
   input wire logic [7:0] level_i,
   output logic pwm_o,
   output logic frame_start_o
);
   logic [7:0] cnt_q, cnt_d;
   logic pwm_q, pwm_d;
   logic start_q, start_d;

   // Frame count and compare, all timing from clk_i only
   always_comb begin
      cnt_d = (cnt_q >= frame_len_i - 8'h01) ? 8'h00 : cnt_q + 8'h01;
      start_d = (cnt_d == 8'h00);
      pwm_d = active_i && (cnt_d < level_i);
      if (!active_i) begin
         cnt_d = 8'h00;
         start_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 8'h00;
         pwm_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         pwm_q <= pwm_d;
         start_q <= start_d;
      end
   end

   assign pwm_o = pwm_q;
   assign frame_start_o = start_q;
endmodule : pwm_modulator
`default_nettype wire

/* File: logic/pwm_stage_fault_shutdown.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_stage_fault_shutdown
   import pwm_stage_pkg::*;
#(
   parameter int unsigned BACKOFF_LEN = BACKOFF_CYCLES,
   parameter int unsigned PAIRS = NUM_PAIRS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sw_mode_i,
   input wire logic [1:0] clk_sel_i,
   input wire logic [8*PAIRS-1:0] sample_i,
   input wire logic [PAIRS-1:0] sample_valid_i,
   input wire logic [1:0] overcurrent_i,
   input wire logic thermal_error_i,
   input wire logic thermal_warning_i,
   input wire logic undervoltage_i,
   output logic [PAIRS-1:0] pwm_out_o,
   output logic [PAIRS-1:0] pwm_oe_o,
   output logic [7:0] levels_o,
   output logic shutdown_o,
   output logic overcurrent_flag_n_o,
   output logic overcurrent_flag_n_oe_o,
   output logic thermal_warning_n_o,
   output logic thermal_warning_n_oe_o,
   output logic undervoltage_flag_n_o,
   output logic undervoltage_flag_n_oe_o
);
   // Cycles-per-frame for a clock selection
   function automatic logic [7:0] frame_of(input logic [1:0] sel);
      unique case (sel)
         CLKSEL_24M576: frame_of = FRAME_24M576;
         CLKSEL_27M000: frame_of = FRAME_27M000;
         default: frame_of = FRAME_18M432;
      endcase
   endfunction : frame_of

   // Quantization levels for a clock selection
   function automatic logic [7:0] levels_of(input logic [1:0] sel);
      levels_of = (sel == CLKSEL_18M432 || sel == 2'h3) ? LEVELS_48 : LEVELS_64;
   endfunction : levels_of

   // Protection sequencer state
   prot_state_e state_q, state_d;
   logic [31:0] timer_q, timer_d;
   logic [2:0] tries_q, tries_d;
   // Clock selection, held duties, drive enables and flags
   logic [1:0] sel_q, sel_d;
   logic sel_init_q, sel_init_d;
   logic [8*PAIRS-1:0] held_q, held_d;
   logic [PAIRS-1:0] oe_q, oe_d;
   logic shut_q, shut_d;
   logic oc_flag_q, oc_flag_d;
   logic tw_flag_q, tw_flag_d;
   logic uv_flag_q, uv_flag_d;
   logic [7:0] lev_q, lev_d;
   // Pair activity and modulator taps
   logic [PAIRS-1:0] pair_act;
   logic [PAIRS-1:0] pwm_raw;
   logic [PAIRS-1:0] frame_start;
   // Fault summaries
   logic oc_any;
   logic hard_fault;
   logic stage_on;

   assign oc_any = |overcurrent_i;
   assign hard_fault = thermal_error_i || undervoltage_i;

   // Protection sequencer
   always_comb begin
      state_d = state_q;
      timer_d = timer_q;
      tries_d = tries_q;
      unique case (state_q)
         ST_RUN: begin
            if (hard_fault) begin
               state_d = ST_SHUTDOWN;
            end else if (oc_any) begin
               state_d = ST_BACKOFF;
               timer_d = 32'h0;
               tries_d = 3'h0;
            end
         end
         ST_BACKOFF: begin
            if (hard_fault) begin
               state_d = ST_SHUTDOWN;
            end else if (timer_q >= BACKOFF_LEN - 1) begin
               state_d = ST_PROBE;
               tries_d = tries_q + 3'h1;
            end else begin
               timer_d = timer_q + 32'h1;
            end
         end
         ST_PROBE: begin
            timer_d = 32'h0;
            if (hard_fault) begin
               state_d = ST_SHUTDOWN;
            end else if (oc_any) begin
               // Failed attempt: back off again or give up
               state_d = (tries_q >= 3'(RETRY_MAX)) ? ST_SHUTDOWN : ST_BACKOFF;
            end else begin
               state_d = ST_RUN;
            end
         end
         // Latched until a reset pulse
         ST_SHUTDOWN: begin
            state_d = ST_SHUTDOWN;
         end
      endcase
   end

   // Stages drive only in normal run and during a retry probe
   assign stage_on = (state_d == ST_RUN) || (state_d == ST_PROBE);

   // Clock selection latched once after reset release; pair enables; flags
   always_comb begin
      sel_init_d = 1'b1;
      sel_d = sel_init_q ? sel_q : clk_sel_i;
      lev_d = levels_of(sel_d);
      shut_d = !stage_on;
      oc_flag_d = oc_any;
      tw_flag_d = thermal_warning_i || thermal_error_i;
      uv_flag_d = undervoltage_i || thermal_error_i;
      for (int i = 0; i < PAIRS; i++) begin
         oe_d[i] = stage_on && pair_act[i];
      end
      held_d = held_q;
      for (int i = 0; i < PAIRS; i++) begin
         // New sample taken only at frame start (or any cycle while the pair is inactive), so switch rate is fixed
         if (sample_valid_i[i] && (frame_start[i] || !pair_act[i])) begin
            held_d[8*i +: 8] = sample_i[8*i +: 8];
         end
      end
   end

   // Sequencer registers; reset restores a full set of retries
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ST_RUN;
         timer_q <= 32'h0;
         tries_q <= 3'h0;
      end else begin
         state_q <= state_d;
         timer_q <= timer_d;
         tries_q <= tries_d;
      end
   end

   // Selection, enable and flag registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel_q <= CLKSEL_18M432;
         sel_init_q <= 1'b0;
         lev_q <= LEVELS_48;
         held_q <= '0;
         oe_q <= '0;
         shut_q <= 1'b0;
         oc_flag_q <= 1'b0;
         tw_flag_q <= 1'b0;
         uv_flag_q <= 1'b0;
      end else begin
         sel_q <= sel_d;
         sel_init_q <= sel_init_d;
         lev_q <= lev_d;
         held_q <= held_d;
         oe_q <= oe_d;
         shut_q <= shut_d;
         oc_flag_q <= oc_flag_d;
         tw_flag_q <= tw_flag_d;
         uv_flag_q <= uv_flag_d;
      end
   end

   // Modulator pairs; third pair only in software mode
   for (genvar g = 0; g < PAIRS; g++) begin : g_pair
      assign pair_act[g] = sw_mode_i || (g < HW_PAIRS);
      pwm_modulator u_mod (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .active_i(pair_act[g]),
         .frame_len_i(frame_of(sel_q)),
         .level_i(held_q[8*g +: 8]),
         .pwm_o(pwm_raw[g]),
         .frame_start_o(frame_start[g])
      );
   end

   // Outputs; modulators keep running while stages float
   assign pwm_out_o = pwm_raw;
   // Drive enables, levels and status straight from registers
   assign pwm_oe_o = oe_q;
   assign levels_o = lev_q;
   assign shutdown_o = shut_q;

   // Open-drain flags: pin driven low when the condition holds
   assign overcurrent_flag_n_o = 1'b0;
   assign overcurrent_flag_n_oe_o = oc_flag_q;
   assign thermal_warning_n_o = 1'b0;
   assign thermal_warning_n_oe_o = tw_flag_q;
   assign undervoltage_flag_n_o = 1'b0;
   assign undervoltage_flag_n_oe_o = uv_flag_q;
endmodule : pwm_stage_fault_shutdown
`default_nettype wire

/* File: verification/pwm_load_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Load behind the stages; a commanded short draws current only while driven
module pwm_load_model #(
   parameter int unsigned PAIRS = 3
) (
   input wire logic [PAIRS-1:0] pwm_oe_i,
   input wire logic [1:0] short_i,
   output logic [1:0] overcurrent_o
);
   // Floated stages carry no current
   always_comb begin
      overcurrent_o = (pwm_oe_i != '0) ? short_i : 2'h0;
   end
endmodule : pwm_load_model
`default_nettype wire

/* File: verification/pwm_stage_props.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_stage_props
   import pwm_stage_pkg::*;
#(
   parameter int unsigned BACKOFF_LEN = 20,
   parameter int unsigned PAIRS = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sw_mode_i,
   input wire logic [1:0] overcurrent_i,
   input wire logic thermal_error_i,
   input wire logic thermal_warning_i,
   input wire logic undervoltage_i,
   input wire logic [PAIRS-1:0] pwm_oe_o,
   input wire logic shutdown_o,
   input wire logic overcurrent_flag_n_oe_o,
   input wire logic thermal_warning_n_oe_o,
   input wire logic undervoltage_flag_n_oe_o
);
   logic [31:0] cnt_q, cnt_d;
   logic hard_q, hard_d;
   // Floated cycle count and hard fault memory
   always_comb begin
      cnt_d = (shutdown_o && pwm_oe_o == '0) ? cnt_q + 32'h1 : 32'h0;
      hard_d = hard_q | thermal_error_i | undervoltage_i;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 32'h0;
         hard_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         hard_q <= hard_d;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_fault_floats: assert property ((thermal_error_i || undervoltage_i)
      |=> shutdown_o && pwm_oe_o == '0) else $error("hard fault not floated");
   a_hard_latched: assert property (hard_q |-> shutdown_o && pwm_oe_o == '0)
      else $error("retry after hard fault");
   a_oc_floats: assert property ((overcurrent_i != '0 && pwm_oe_o != '0)
      |=> shutdown_o && pwm_oe_o == '0) else $error("over-current not floated");
   a_backoff_len: assert property ($fell(shutdown_o) |-> cnt_q == BACKOFF_LEN)
      else $error("back-off length wrong");
   a_probe_ok: assert property (($fell(shutdown_o) && overcurrent_i == '0)
      |=> !shutdown_o && pwm_oe_o != '0) else $error("good probe not resumed");
   a_oc_flag: assert property (1'b1 |=> overcurrent_flag_n_oe_o == ($past(overcurrent_i) != 2'h0))
      else $error("over-current flag wrong");
   a_tw_flag: assert property (1'b1
      |=> thermal_warning_n_oe_o == ($past(thermal_warning_i) | $past(thermal_error_i)))
      else $error("warning flag wrong");
   a_uv_flag: assert property (1'b1
      |=> undervoltage_flag_n_oe_o == ($past(undervoltage_i) | $past(thermal_error_i)))
      else $error("under-voltage flag wrong");
   a_hw_pairs: assert property (!sw_mode_i |-> !pwm_oe_o[PAIRS-1])
      else $error("third pair driven");
endmodule : pwm_stage_props
bind pwm_stage_fault_shutdown pwm_stage_props #(.BACKOFF_LEN(BACKOFF_LEN), .PAIRS(PAIRS)) u_props (
   .clk_i, .rst_i, .sw_mode_i, .overcurrent_i, .thermal_error_i, .thermal_warning_i,
   .undervoltage_i, .pwm_oe_o, .shutdown_o, .overcurrent_flag_n_oe_o, .thermal_warning_n_oe_o,
   .undervoltage_flag_n_oe_o);
`default_nettype wire

/* File: verification/tb_pwm_stage_fault_shutdown.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_pwm_stage_fault_shutdown;
   import pwm_stage_pkg::*;
   localparam int unsigned BL = 20;
   logic clk_i = 0, rst_i = 1, sw_mode_i = 0, thermal_error_i = 0, chk = 0;
   logic thermal_warning_i = 0, undervoltage_i = 0, shutdown_o;
   logic overcurrent_flag_n_oe_o, thermal_warning_n_oe_o, undervoltage_flag_n_oe_o;
   logic [1:0] clk_sel_i = 0, short_q = 0, oc, prev = 0;
   logic [23:0] sample_i = 0;
   logic [2:0] sample_valid_i = 3'h7, pwm_out_o, pwm_oe_o, m;
   logic [7:0] levels_o, lv;
   logic [14:0] notes[$], exp_v;
   int failures = 0, n_compared = 0, probes = 0, toggles = 0, p0, t0;
   pwm_stage_fault_shutdown #(.BACKOFF_LEN(BL)) dut (.clk_i, .rst_i, .sw_mode_i, .clk_sel_i,
      .sample_i, .sample_valid_i, .overcurrent_i(oc), .thermal_error_i, .thermal_warning_i,
      .undervoltage_i, .pwm_out_o, .pwm_oe_o, .levels_o, .shutdown_o, .overcurrent_flag_n_o(),
      .overcurrent_flag_n_oe_o, .thermal_warning_n_o(), .thermal_warning_n_oe_o,
      .undervoltage_flag_n_o(), .undervoltage_flag_n_oe_o);
   pwm_load_model load (.pwm_oe_i(pwm_oe_o), .short_i(short_q), .overcurrent_o(oc));
   // Clock
   initial forever #12.5 clk_i = ~clk_i;
   // Random duties, edge counters, result checker
   always @(posedge clk_i) begin
      sample_i <= {3{8'h08 + 8'($urandom() % 32)}};
      prev <= {pwm_oe_o[0], pwm_out_o[0]};
      probes += int'(pwm_oe_o[0] && !prev[1]);
      toggles += int'(pwm_out_o[0] != prev[0]);
      if (chk === 1'b1) begin
         exp_v = notes.pop_front();
         `CHECK({shutdown_o, pwm_oe_o, overcurrent_flag_n_oe_o, thermal_warning_n_oe_o,
            undervoltage_flag_n_oe_o, levels_o}, exp_v)
      end
   end
   task automatic expect_out(input logic sd, input logic [2:0] oe, input logic [2:0] fl);
      notes.push_back({sd, oe, fl, lv});
      chk <= 1'b1;
      @(posedge clk_i);
      chk <= 1'b0;
      @(posedge clk_i);
   endtask : expect_out
   task automatic do_reset(input logic [1:0] sel, input logic sw);
      rst_i <= 1'b1;
      clk_sel_i <= sel;
      sw_mode_i <= sw;
      {thermal_error_i, thermal_warning_i, undervoltage_i, short_q} <= '0;
      m = sw ? 3'h7 : 3'h3;
      lv = (sel == 2'h1 || sel == 2'h2) ? LEVELS_64 : LEVELS_48;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : do_reset
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   // Hard faults, warning alone, single over-current, then a lasting short
   initial begin
      void'($urandom(32'h9FF400CC));
      for (int s = 0; s < 4; s++) begin
         do_reset(2'(s), s[0]);
         expect_out(1'b0, m, 3'h0);
         case (s)
            0: thermal_error_i <= 1'b1;
            1: undervoltage_i <= 1'b1;
            2: thermal_warning_i <= 1'b1;
            default: short_q <= 2'h1;
         endcase
         @(posedge clk_i);
         if (s == 2) expect_out(1'b0, m, 3'h2);
         else expect_out(1'b1, 3'h0, s == 0 ? 3'h3 : s == 1 ? 3'h1 : 3'h4);
         {thermal_error_i, thermal_warning_i, undervoltage_i, short_q} <= '0;
         repeat (8) @(posedge clk_i);
         expect_out(s != 2, s == 2 ? m : 3'h0, 3'h0);
         repeat (BL) @(posedge clk_i);
         expect_out(s < 2, s < 2 ? 3'h0 : m, 3'h0);
         $display("test %0d done", s);
      end
      do_reset(2'h1, 1'b1);
      p0 = probes;
      short_q <= 2'h3;
      repeat (6 * (BL + 3)) @(posedge clk_i);
      `CHECK(probes - p0, 5)
      expect_out(1'b1, 3'h0, 3'h0);
      t0 = toggles;
      repeat (100) @(posedge clk_i);
      `CHECK(toggles != t0, 1'b1)
      $display("test 4 done");
      test_done();
   end
   // Watchdog
   initial begin
      #50000;
      failures++;
      test_done();
   end
endmodule : tb_pwm_stage_fault_shutdown
`default_nettype wire
